// file: logic/rtfc_params.svh
/*
 * constants of the radio command register block: command codes, reset words,
 * frequency word limits, band tuning figures and timing counts.
 * assumes a 20 MHz system clock; included by the main module only.
 */
`ifndef RTFC_PARAMS_SVH
`define RTFC_PARAMS_SVH

// ===
// clock and timing
`define RTFC_CLK_HZ        20000000
`define RTFC_ADJ_TIME_NS   1000
`define RTFC_ADJ_CYC       ((`RTFC_ADJ_TIME_NS * (`RTFC_CLK_HZ / 1000000) + 999) / 1000)
`define RTFC_BIT_DIV       20

// ===
// command codes (leading bits of a 16-bit frame)
`define RTFC_OP_STATUS     1'h0
`define RTFC_OP_AFA        8'hC4
`define RTFC_OP_TXCFG      7'h4C
`define RTFC_OP_TXBYTE     8'hB8
`define RTFC_OP_FREQ       4'hA
`define RTFC_OP_RXCTL      5'h12

// ===
// reset words
`define RTFC_RST_AFA       16'hC4F7
`define RTFC_RST_TXCFG     16'h9800
`define RTFC_RST_TXBYTE    16'hB8AA
`define RTFC_RST_FREQ      16'hA680
`define RTFC_RST_RXCTL     16'h9080

// ===
// frequency word limits and band figures
`define RTFC_WORD_MIN      12'h060
`define RTFC_WORD_MAX      12'hF3F
`define RTFC_BAND_433      2'h1
`define RTFC_BAND_868      2'h2
`define RTFC_BAND_916      2'h3
`define RTFC_STEP_433      13'h09C4
`define RTFC_STEP_868      13'h1388
`define RTFC_STEP_916      13'h1D4C
`define RTFC_BASE_433      32'h19A14780
`define RTFC_BASE_868      32'h33428F00
`define RTFC_BASE_916      32'h35A4E900
`define RTFC_DEV_STEP_KHZ  8'h0F
`define RTFC_PWR_STEP_DB   5'h03

`endif

// file: logic/rtfc_pkg.sv
/*
 * types of the radio command register block: register field layouts and
 * state enumerations.
 * assumes nothing beyond the constants header.
 */
package rtfc_pkg;

	// ===
	// register layouts
	typedef struct packed {
		logic [7:0] cmd;
		logic [1:0] auto_mode;
		logic [1:0] range_code;
		logic       adjust_sample_strobe;
		logic       fine_adjust_mode;
		logic       offset_apply_enable;
		logic       offset_calc_enable;
	} rtfc_afa_t;

	typedef struct packed {
		logic [6:0] cmd;
		logic       deviation_polarity_invert;
		logic [3:0] deviation_code;
		logic       unused;
		logic [2:0] tx_power_code;
	} rtfc_txcfg_t;

	typedef struct packed {
		logic [3:0]  cmd;
		logic [11:0] carrier_word;
	} rtfc_freq_t;

	typedef struct packed {
		logic [4:0] cmd;
		logic       pin16_function_select;
		logic [1:0] valid_data_response;
		logic [2:0] baseband_bw_code;
		logic [1:0] lna_gain_code;
		logic [2:0] signal_threshold_code;
	} rtfc_rxctl_t;

	// ===
	// states
	typedef enum logic [2:0] {FR_IDLE, FR_CMD, FR_STREAM, FR_STATUS, FR_DONE} rtfc_frame_t;
	typedef enum logic {AJ_IDLE, AJ_BUSY} rtfc_adj_t;

endpackage : rtfc_pkg

// file: logic/rtfc_fifo.sv
/*
 * small synchronous fifo with valid/ready on both sides; entries held in
 * flip-flops, head word read from the entry register.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module rtfc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    wr_nxt;
	logic [AW-1:0]    rd_r;
	logic [AW-1:0]    rd_nxt;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             push;
	logic             pop;

	// honest full and empty from the fill count
	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointer and count update
	always_comb begin
		wr_nxt  = wr_r;
		rd_nxt  = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wr_nxt = (wr_r == AW'(DEPTH-1)) ? '0 : AW'(wr_r + 1'b1);
		end
		if (pop) begin
			rd_nxt = (rd_r == AW'(DEPTH-1)) ? '0 : AW'(rd_r + 1'b1);
		end
		if (push && !pop) begin
			cnt_nxt = (AW+1)'(cnt_r + 1'b1);
		end else if (pop && !push) begin
			cnt_nxt = (AW+1)'(cnt_r - 1'b1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// entry storage, one register per word
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_ent
			always_ff @(posedge clk) begin
				if (push && wr_r == AW'(gi)) begin
					mem_r[gi] <= in_data;
				end
			end
		end
	endgenerate

endmodule : rtfc_fifo

`default_nettype wire

// file: logic/rtfc_regs.sv
/*
 * serial command register bank of an fsk transceiver: frame decoding, status
 * read, frequency adjust unit, transmit configuration, transmit byte stream
 * through a fifo, carrier word with range check, receiver control.
 * assumes the serial pins come from another clock domain and are sampled by
 * clk (20 MHz); band, transmit enable and data register enable are same-domain.
 */
`timescale 1ns/10ps
`default_nettype none

`include "rtfc_params.svh"

// Contract
// RULE_01: writing the strobe bit one samples the signal and computes an offset.
// RULE_02: host clears the strobe bit before requesting another offset sample.
// RULE_03: fine mode doubles offset measurement time for higher accuracy.
// RULE_04: apply bit adds computed offset to synthesizer word; clear adds nothing.
// RULE_05: calculation bit enables offset computation; clear means no offset computed.
// RULE_06: tuning step is 2.5, 5 or 7.5 kHz for the three bands.
// RULE_07: transmit configuration command is 1001100, reset word 9800 hex.
// RULE_08: polarity clear maps zero to lower frequency; set inverts the mapping.
// RULE_09: deviation code n gives 15 times (n+1) kHz deviation.
// RULE_10: host writes zero into unused bit 3 of transmit configuration.
// RULE_11: power code n gives maximum power minus 3n dB.
// RULE_12: transmit byte command B8 loads a byte; reset word B8AA hex.
// RULE_13: without data register enable host modulates through the data pin.
// RULE_14: enabling transmitter sends register content at once, AA after reset.
// RULE_15: serial data output high means next transmit byte may be written.
// RULE_16: host should preload a preamble rather than rely on reset value.
// RULE_17: with select held low, each byte after the command loads transmit data.
// RULE_18: frequency command 1010 carries a 12-bit word; reset word A680 hex.
// RULE_19: frequency word outside 96 to 3903 is ignored, old word kept.
// RULE_20: carrier equals 10*B1*(B0+word/4000) MHz per band.
// RULE_21: receiver control command 10010, reset 9080 hex, holds receiver fields.
// RULE_22: frame starting with zero is a status read; writes start with one.
// RULE_23: transmit byte register used only when data register enable is set.
// RULE_24: commands decoded by leading bits; only the addressed register changes.
module rtfc_regs
	import rtfc_pkg::*;
#(
	parameter int ADJ_CYC    = `RTFC_ADJ_CYC,
	parameter int BIT_DIV    = `RTFC_BIT_DIV,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  spi_sck,
	input  wire logic                  spi_cs_n,
	input  wire logic                  spi_sdi,
	output logic                       spi_sdo,
	input  wire logic                  tx_data_pin,
	input  wire logic                  tx_data_reg_enable,
	input  wire logic                  tx_enable,
	input  wire logic [1:0]            band_code,
	input  wire logic [4:0]            adj_meas_offset,
	output rtfc_pkg::rtfc_afa_t        afa_o,
	output rtfc_pkg::rtfc_txcfg_t      txcfg_o,
	output rtfc_pkg::rtfc_freq_t       freq_o,
	output rtfc_pkg::rtfc_rxctl_t      rxctl_o,
	output logic                       adj_busy_o,
	output logic [4:0]                 adj_offset_o,
	output logic [12:0]                synth_word_o,
	output logic [31:0]                carrier_hz_o,
	output logic [12:0]                step_hz_o,
	output logic [7:0]                 dev_khz_o,
	output logic [4:0]                 atten_db_o,
	output logic                       tx_active_o,
	output logic                       tx_freq_high_o
);

	localparam int AW = $clog2(2 * ADJ_CYC + 1);
	localparam int DW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

	// ===
	// pin synchronisers
	logic [3:0] sy1_r;
	logic [3:0] sy2_r;
	logic       sck_d_r;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_n_s;
	logic       sdi_s;
	logic       pin_s;

	// two flops per pin, then edge detect on the second
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sy1_r   <= 4'h4;
			sy2_r   <= 4'h4;
			sck_d_r <= 1'h0;
		end else begin
			sy1_r   <= {spi_sck, spi_cs_n, spi_sdi, tx_data_pin};
			sy2_r   <= sy1_r;
			sck_d_r <= sy2_r[3];
		end
	end

	assign sck_rise = sy2_r[3] & ~sck_d_r;
	assign sck_fall = ~sy2_r[3] & sck_d_r;
	assign cs_n_s   = sy2_r[2];
	assign sdi_s    = sy2_r[1];
	assign pin_s    = sy2_r[0];

	// ===
	// serial frame decoding and command registers
	rtfc_frame_t fr_r;
	rtfc_frame_t fr_nxt;
	logic [4:0]  cnt_r;
	logic [4:0]  cnt_nxt;
	logic [15:0] sh_r;
	logic [15:0] sh_nxt;
	logic [15:0] stat_r;
	logic [15:0] stat_nxt;
	rtfc_afa_t   afa_r;
	rtfc_afa_t   afa_nxt;
	rtfc_txcfg_t txcfg_r;
	rtfc_txcfg_t txcfg_nxt;
	rtfc_freq_t  freq_r;
	rtfc_freq_t  freq_nxt;
	rtfc_rxctl_t rxctl_r;
	rtfc_rxctl_t rxctl_nxt;
	logic        push;
	logic        push_ready;
	logic        adj_tog_r;
	logic [4:0]  adj_off_r;

	// shift on sck rise, decode at byte and word boundaries
	always_comb begin
		fr_nxt    = fr_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		stat_nxt  = stat_r;
		afa_nxt   = afa_r;
		txcfg_nxt = txcfg_r;
		freq_nxt  = freq_r;
		rxctl_nxt = rxctl_r;
		push      = 1'h0;
		if (cs_n_s) begin
			fr_nxt  = FR_IDLE;
			cnt_nxt = 5'h00;
		end else if (sck_rise) begin
			sh_nxt  = {sh_r[14:0], sdi_s};
			cnt_nxt = 5'(cnt_r + 1'b1);
			unique case (fr_r)
				FR_IDLE: begin
					if (sdi_s == `RTFC_OP_STATUS) begin // [RULE_22]
						fr_nxt   = FR_STATUS;
						stat_nxt = {10'h000, adj_tog_r, adj_off_r};
					end else begin
						fr_nxt = FR_CMD;
					end
				end
				FR_CMD: begin
					if (cnt_r == 5'h07 && sh_nxt[7:0] == `RTFC_OP_TXBYTE) begin // [RULE_12]
						fr_nxt  = FR_STREAM;
						cnt_nxt = 5'h00;
					end else if (cnt_r == 5'h0F) begin
						fr_nxt = FR_DONE;
						if (sh_nxt[15:8] == `RTFC_OP_AFA) begin // [RULE_24]
							afa_nxt = sh_nxt;
						end else if (sh_nxt[15:9] == `RTFC_OP_TXCFG) begin // [RULE_07]
							txcfg_nxt = sh_nxt;
						end else if (sh_nxt[15:12] == `RTFC_OP_FREQ) begin // [RULE_18]
							if (sh_nxt[11:0] >= `RTFC_WORD_MIN && sh_nxt[11:0] <= `RTFC_WORD_MAX) begin
								freq_nxt = sh_nxt; // [RULE_19]
							end
						end else if (sh_nxt[15:11] == `RTFC_OP_RXCTL) begin // [RULE_21]
							rxctl_nxt = sh_nxt;
						end
					end
				end
				FR_STREAM: begin
					if (cnt_r == 5'h07) begin // [RULE_17]
						push    = 1'h1;
						cnt_nxt = 5'h00;
					end
				end
				FR_STATUS, FR_DONE: begin
					cnt_nxt = (cnt_r == 5'h1F) ? cnt_r : 5'(cnt_r + 1'b1);
				end
			endcase
		end else if (sck_fall && fr_r == FR_STATUS && cnt_r >= 5'h02) begin
			stat_nxt = {stat_r[14:0], 1'h0};
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			fr_r    <= FR_IDLE;
			cnt_r   <= 5'h00;
			sh_r    <= 16'h0000;
			stat_r  <= 16'h0000;
			afa_r   <= `RTFC_RST_AFA;
			txcfg_r <= `RTFC_RST_TXCFG; // [RULE_07]
			freq_r  <= `RTFC_RST_FREQ; // [RULE_18]
			rxctl_r <= `RTFC_RST_RXCTL; // [RULE_21]
		end else begin
			fr_r    <= fr_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			stat_r  <= stat_nxt;
			afa_r   <= afa_nxt;
			txcfg_r <= txcfg_nxt;
			freq_r  <= freq_nxt;
			rxctl_r <= rxctl_nxt;
		end
	end

	// status bits during a status read, otherwise the fifo room flag while selected
	assign spi_sdo = (fr_r == FR_STATUS) ? stat_r[15] : (~cs_n_s & push_ready); // [RULE_15]
	assign afa_o   = afa_r;
	assign txcfg_o = txcfg_r;
	assign freq_o  = freq_r;
	assign rxctl_o = rxctl_r;

	// ===
	// frequency adjust unit
	rtfc_adj_t   adj_r;
	rtfc_adj_t   adj_nxt;
	logic [AW-1:0] adj_cnt_r;
	logic [AW-1:0] adj_cnt_nxt;
	logic [4:0]  adj_off_nxt;
	logic        adj_tog_nxt;
	logic        adjust_sample_strobe_d_r;
	logic        adjust_sample_strobe_rise;

	// only a fresh strobe starts a sample; a held one does not repeat
	assign adjust_sample_strobe_rise = afa_r.adjust_sample_strobe & ~adjust_sample_strobe_d_r; // [RULE_02]

	// measurement timer and offset capture
	always_comb begin
		adj_nxt     = adj_r;
		adj_cnt_nxt = adj_cnt_r;
		adj_off_nxt = adj_off_r;
		adj_tog_nxt = adj_tog_r;
		unique case (adj_r)
			AJ_IDLE: begin
				if (adjust_sample_strobe_rise && afa_r.offset_calc_enable) begin // [RULE_01] [RULE_05]
					adj_nxt     = AJ_BUSY;
					adj_cnt_nxt = afa_r.fine_adjust_mode ? AW'(2 * ADJ_CYC - 1) : AW'(ADJ_CYC - 1); // [RULE_03]
				end
			end
			AJ_BUSY: begin
				if (!afa_r.offset_calc_enable) begin // [RULE_05]
					adj_nxt = AJ_IDLE;
				end else if (adj_cnt_r == '0) begin
					adj_nxt     = AJ_IDLE;
					adj_off_nxt = adj_meas_offset; // [RULE_01]
					adj_tog_nxt = ~adj_tog_r;
				end else begin
					adj_cnt_nxt = AW'(adj_cnt_r - 1'b1);
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			adj_r     <= AJ_IDLE;
			adj_cnt_r <= '0;
			adj_off_r <= 5'h00;
			adj_tog_r <= 1'h0;
			adjust_sample_strobe_d_r  <= 1'h0;
		end else begin
			adj_r     <= adj_nxt;
			adj_cnt_r <= adj_cnt_nxt;
			adj_off_r <= adj_off_nxt;
			adj_tog_r <= adj_tog_nxt;
			adjust_sample_strobe_d_r  <= afa_r.adjust_sample_strobe;
		end
	end

	assign adj_busy_o   = (adj_r == AJ_BUSY);
	assign adj_offset_o = adj_off_r;

	// ===
	// tuning and transmit figures
	logic [12:0] step_nxt;
	logic [31:0] base_nxt;
	logic [12:0] synth_nxt;

	// band step and base, offset applied to the synthesizer word
	always_comb begin
		unique case (band_code)
			`RTFC_BAND_433: begin
				step_nxt = `RTFC_STEP_433; // [RULE_06]
				base_nxt = `RTFC_BASE_433; // [RULE_20]
			end
			`RTFC_BAND_868: begin
				step_nxt = `RTFC_STEP_868; // [RULE_06]
				base_nxt = `RTFC_BASE_868; // [RULE_20]
			end
			`RTFC_BAND_916: begin
				step_nxt = `RTFC_STEP_916; // [RULE_06]
				base_nxt = `RTFC_BASE_916; // [RULE_20]
			end
			default: begin
				step_nxt = 13'h0000;
				base_nxt = 32'h00000000;
			end
		endcase
		synth_nxt = {1'h0, freq_r.carrier_word};
		if (afa_r.offset_apply_enable) begin // [RULE_04]
			synth_nxt = 13'(synth_nxt + {{8{adj_off_r[4]}}, adj_off_r});
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			step_hz_o    <= 13'h0000;
			carrier_hz_o <= 32'h00000000;
			synth_word_o <= 13'h0000;
			dev_khz_o    <= 8'h00;
			atten_db_o   <= 5'h00;
		end else begin
			step_hz_o    <= step_nxt;
			carrier_hz_o <= 32'(base_nxt + 32'(step_nxt * freq_r.carrier_word)); // [RULE_20]
			synth_word_o <= synth_nxt;
			dev_khz_o    <= 8'(`RTFC_DEV_STEP_KHZ * (txcfg_r.deviation_code + 8'h01)); // [RULE_09]
			atten_db_o   <= 5'(`RTFC_PWR_STEP_DB * txcfg_r.tx_power_code); // [RULE_11]
		end
	end

	// ===
	// transmit byte path
	logic          fifo_valid;
	logic          pop;
	logic [7:0]    fifo_data;
	logic [7:0]    txb_r;
	logic [7:0]    txb_nxt;
	logic [2:0]    idx_r;
	logic [2:0]    idx_nxt;
	logic [DW-1:0] div_r;
	logic [DW-1:0] div_nxt;
	logic          run;
	logic          tick;
	logic          mod_bit;

	rtfc_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (push),
		.in_ready  (push_ready),
		.in_data   (sh_nxt[7:0]),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data)
	);

	assign run  = tx_enable & tx_data_reg_enable; // [RULE_23]
	assign tick = run && div_r == DW'(BIT_DIV - 1);
	// preload while idle, refill after the last bit of a byte
	assign pop  = fifo_valid & (~run | (tick & idx_r == 3'h7));

	// bit timer and byte serialiser, msb first
	always_comb begin
		txb_nxt = txb_r;
		idx_nxt = idx_r;
		div_nxt = div_r;
		if (!run) begin
			idx_nxt = 3'h0; // [RULE_14]
			div_nxt = '0;
		end else if (tick) begin
			div_nxt = '0;
			idx_nxt = 3'(idx_r + 1'b1);
		end else begin
			div_nxt = DW'(div_r + 1'b1);
		end
		if (pop) begin
			txb_nxt = fifo_data; // [RULE_12]
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			txb_r <= 8'(`RTFC_RST_TXBYTE & 16'h00FF); // [RULE_14]
			idx_r <= 3'h0;
			div_r <= '0;
		end else begin
			txb_r <= txb_nxt;
			idx_r <= idx_nxt;
			div_r <= div_nxt;
		end
	end

	// register bit or the synchronised data pin, then polarity
	assign mod_bit = tx_data_reg_enable ? txb_r[3'h7 - idx_r] : pin_s; // [RULE_23]

	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_active_o    <= 1'h0;
			tx_freq_high_o <= 1'h0;
		end else begin
			tx_active_o    <= tx_enable;
			tx_freq_high_o <= mod_bit ^ txcfg_r.deviation_polarity_invert; // [RULE_08]
		end
	end

endmodule : rtfc_regs

`default_nettype wire

// file: tb/rtfc_regs_props.sv
/*
 * checker for the radio command register bank: relations between its ports.
 * assumes a bind onto rtfc_regs, one clock domain with a synchronous reset.
 */
`timescale 1ns/10ps
`default_nettype none

module rtfc_regs_props #(
	parameter int ADJ_CYC = 20
) (
	input wire logic                  clk,
	input wire logic                  rstn,
	input wire logic                  spi_cs_n,
	input wire logic                  spi_sdo,
	input wire logic                  tx_data_pin,
	input wire logic                  tx_data_reg_enable,
	input wire logic [1:0]            band_code,
	input wire rtfc_pkg::rtfc_afa_t   afa_o,
	input wire rtfc_pkg::rtfc_txcfg_t txcfg_o,
	input wire rtfc_pkg::rtfc_freq_t  freq_o,
	input wire rtfc_pkg::rtfc_rxctl_t rxctl_o,
	input wire logic                  adj_busy_o,
	input wire logic [4:0]            adj_offset_o,
	input wire logic [12:0]           synth_word_o,
	input wire logic [31:0]           carrier_hz_o,
	input wire logic [12:0]           step_hz_o,
	input wire logic [7:0]            dev_khz_o,
	input wire logic [4:0]            atten_db_o,
	input wire logic                  tx_freq_high_o
);
	import rtfc_pkg::*;

	logic [7:0]  busy_cnt_r;
	logic [7:0]  busy_cnt_nxt;
	logic [31:0] car_exp;

	// ===
	// helpers: busy run length, expected carrier in Hz
	always_comb begin
		busy_cnt_nxt = adj_busy_o ? busy_cnt_r + 8'h01 : 8'h00;
	end
	always_ff @(posedge clk) begin
		busy_cnt_r <= rstn ? busy_cnt_nxt : 8'h00;
	end
	assign car_exp = 32'(band_code) * (((band_code == 2'h3) ? 32'h11E1A300 : 32'h19A14780)
		+ 32'h9C4 * 32'(freq_o.carrier_word));

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ===
	// assertions
	a_cmd_codes: assert property (
		afa_o.cmd == 8'hC4 && txcfg_o.cmd == 7'h4C && freq_o.cmd == 4'hA && rxctl_o.cmd == 5'h12)
		else $error("command bits of a register changed");
	a_word_range: assert property (
		freq_o.carrier_word >= 12'h060 && freq_o.carrier_word <= 12'hF3F)
		else $error("carrier word outside its range");
	a_dev_figure: assert property (
		$past(rstn) && $stable(txcfg_o) |-> dev_khz_o == 8'h0F * (8'(txcfg_o.deviation_code) + 8'h01))
		else $error("deviation figure wrong");
	a_pwr_figure: assert property (
		$past(rstn) && $stable(txcfg_o) |-> atten_db_o == 5'h03 * 5'(txcfg_o.tx_power_code))
		else $error("power figure wrong");
	a_carrier_fig: assert property (
		$past(rstn) && $stable(freq_o) && $stable(band_code) |-> carrier_hz_o == car_exp)
		else $error("carrier figure wrong");
	a_step_fig: assert property (
		$past(rstn) && $stable(band_code) |-> step_hz_o == 13'h9C4 * 13'(band_code))
		else $error("tuning step wrong");
	a_busy_cause: assert property (
		$rose(adj_busy_o) |-> afa_o.offset_calc_enable && afa_o.adjust_sample_strobe)
		else $error("adjust started without strobe and calc enable");
	a_busy_len: assert property (
		$fell(adj_busy_o) && afa_o.offset_calc_enable && $stable(afa_o)
		|-> 32'(busy_cnt_r) == (afa_o.fine_adjust_mode ? 2 * ADJ_CYC : ADJ_CYC))
		else $error("adjust run length wrong");
	a_offset_sum: assert property (
		$past(rstn) && $stable(afa_o) && $stable(freq_o) && $stable(adj_offset_o)
		|-> synth_word_o == {1'b0, freq_o.carrier_word}
		+ (afa_o.offset_apply_enable ? {{8{adj_offset_o[4]}}, adj_offset_o} : 13'h0000))
		else $error("synthesizer word wrong");
	a_manual_mod: assert property (
		(!tx_data_reg_enable && $stable(tx_data_pin) && $stable(txcfg_o)) [*6]
		|-> tx_freq_high_o == (tx_data_pin ^ txcfg_o.deviation_polarity_invert))
		else $error("manual modulation wrong");
	a_sdo_idle: assert property (
		spi_cs_n [*4] |-> !spi_sdo)
		else $error("serial out high while deselected");

endmodule : rtfc_regs_props

`default_nettype wire

// file: tb/rtfc_host_model.sv
/*
 * host controller model: drives command frames and byte streams, msb first.
 * assumes a 400 ns serial clock that stands low outside frames.
 */
`timescale 1ns/10ps
`default_nettype none

module rtfc_host_model (
	output var logic spi_sck,
	output var logic spi_cs_n,
	output var logic spi_sdi,
	input  wire logic spi_sdo
);
	localparam time HALF = 200ns;

	// idle link at time zero
	initial begin
		spi_sck  = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi  = 1'b0;
	end

	// ===
	// frame pieces; select held low across bytes for streaming
	task automatic open_frame();
		spi_cs_n = 1'b0;
		#HALF;
	endtask : open_frame

	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			spi_sdi = b[i];
			#HALF spi_sck = 1'b1;
			#HALF spi_sck = 1'b0;
		end
	endtask : send_byte

	task automatic close_frame();
		#HALF spi_cs_n = 1'b1;
		spi_sdi = ~spi_sdi; // released line shows no stale bit
		#HALF;
	endtask : close_frame

	task automatic cmd(input logic [15:0] w);
		open_frame();
		send_byte(w[15:8]);
		send_byte(w[7:0]);
		close_frame();
	endtask : cmd

endmodule : rtfc_host_model

`default_nettype wire

// file: tb/rtfc_regs_tb_top.sv
/*
 * testbench of the radio command register bank: directed scenarios.
 * assumes host model and checker compiled alongside.
 */
`timescale 1ns/10ps
`default_nettype none

module rtfc_regs_tb_top;
	import rtfc_pkg::*;

	localparam int ADJ  = 20;
	localparam int BDIV = 20;
	logic          clk = 1'b0;
	logic          rstn;
	logic          tx_data_pin;
	logic          tx_data_reg_enable;
	logic          tx_enable;
	logic [1:0]    band_code;
	logic [4:0]    adj_meas_offset;
	logic          spi_sck, spi_cs_n, spi_sdi, spi_sdo, adj_busy_o, tx_freq_high_o;
	rtfc_afa_t     afa_o;
	rtfc_txcfg_t   txcfg_o;
	rtfc_freq_t    freq_o;
	rtfc_rxctl_t   rxctl_o;
	logic [4:0]    adj_offset_o, atten_db_o;
	logic [12:0]   synth_word_o, step_hz_o;
	logic [31:0]   carrier_hz_o;
	logic [7:0]    dev_khz_o;
	int            num_errors = 0;
	int            cmp_count = 0;

	// 20 MHz clock
	always #25 clk = ~clk;

	rtfc_host_model host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

	rtfc_regs dut (
		.clk(clk), .rstn(rstn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .tx_data_pin(tx_data_pin), .tx_data_reg_enable(tx_data_reg_enable),
		.tx_enable(tx_enable), .band_code(band_code), .adj_meas_offset(adj_meas_offset),
		.afa_o(afa_o), .txcfg_o(txcfg_o), .freq_o(freq_o), .rxctl_o(rxctl_o),
		.adj_busy_o(adj_busy_o), .adj_offset_o(adj_offset_o), .synth_word_o(synth_word_o),
		.carrier_hz_o(carrier_hz_o), .step_hz_o(step_hz_o), .dev_khz_o(dev_khz_o),
		.atten_db_o(atten_db_o), .tx_active_o(), .tx_freq_high_o(tx_freq_high_o));

	// ===
	// common tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s seen %0h wanted %0h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic end_sim();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	// run one byte, check mid-bit
	task automatic tx_bits(input logic [7:0] b, input logic pol);
		tx_enable = 1'b1;
		tick(1 + BDIV / 2);
		for (int k = 7; k >= 0; k--) begin
			chk(32'(tx_freq_high_o), 32'(b[k] ^ pol), "tx bit");
			tick(BDIV);
		end
		tx_enable = 1'b0;
		tick(2);
	endtask : tx_bits

	// busy cycles around one command
	task automatic busy_len(input logic [15:0] w, input logic [31:0] exp);
		logic [31:0] cnt;
		cnt = 32'h0;
		fork
			host.cmd(w);
			repeat (200) begin
				@(posedge clk);
				#1;
				if (adj_busy_o === 1'b1) cnt++;
			end
		join
		chk(cnt, exp, "busy length");
	endtask : busy_len

	// ===
	// scenarios
	task automatic t_reset_tx();
		chk({afa_o, txcfg_o}, 32'hC4F79800, "reset a");
		chk({freq_o, rxctl_o}, 32'hA6809080, "reset b");
		tx_data_reg_enable = 1'b1;
		tx_bits(8'hAA, 1'b0);
		host.open_frame();
		host.send_byte(8'hB8);
		host.send_byte(8'h55); // preamble preload, then overwritten
		host.send_byte(8'h3C);
		host.close_frame();
		tick(4);
		tx_bits(8'h3C, 1'b0);
	endtask : t_reset_tx

	task automatic t_decode();
		host.cmd(16'h97FF);
		host.cmd(16'h0000); // status read frame
		host.cmd(16'hD2FF); // unmapped code
		tick(3);
		chk({afa_o, txcfg_o}, 32'hC4F79800, "decode a");
		chk({freq_o, rxctl_o}, 32'hA68097FF, "decode b");
	endtask : t_decode

	task automatic t_txcfg();
		for (int n = 0; n < 16; n++) begin
			host.cmd({7'h4C, n[0], n[3:0], 1'b0, n[2:0]});
			tick(3);
			chk(32'(txcfg_o), {16'h0, 7'h4C, n[0], n[3:0], 1'b0, n[2:0]}, "txcfg");
			chk(32'(dev_khz_o), 32'h0F * 32'(n + 1), "deviation");
			chk(32'(atten_db_o), 32'h03 * 32'(n % 8), "power");
		end
	endtask : t_txcfg

	task automatic t_manual();
		tx_data_reg_enable = 1'b0; // pin modulation
		for (int p = 0; p < 2; p++) begin
			host.cmd({7'h4C, p[0], 8'h00});
			for (int d = 0; d < 2; d++) begin
				tx_data_pin = d[0];
				tick(8);
				chk(32'(tx_freq_high_o), 32'(d[0] ^ p[0]), "manual");
			end
		end
	endtask : t_manual

	task automatic t_freq();
		logic [31:0] b1, b0;
		for (int b = 1; b <= 3; b++) begin
			band_code = 2'(b);
			b1 = 32'(b);
			b0 = (b == 3) ? 32'h11E1A300 : 32'h19A14780;
			host.cmd(16'hA060);
			tick(3);
			chk(carrier_hz_o, b1 * (b0 + 32'h9C4 * 32'h60), "low word");
			chk(32'(step_hz_o), 32'h9C4 * b1, "step");
			host.cmd(16'hAF3F);
			host.cmd(16'hA05F);
			host.cmd(16'hAF40);
			tick(3);
			chk(32'(freq_o), 32'h0000AF3F, "range");
			chk(carrier_hz_o, b1 * (b0 + 32'h9C4 * 32'hF3F), "high word");
		end
	endtask : t_freq

	task automatic t_adjust();
		adj_meas_offset = 5'h1D;
		busy_len(16'hC4FF, 32'(2 * ADJ)); // fine mode
		chk(32'(adj_offset_o), 32'h1D, "offset");
		chk(32'(synth_word_o), 32'h0F3C, "offset sum");
		busy_len(16'hC4F7, 32'h0); // strobe back to zero
		adj_meas_offset = 5'h04;
		busy_len(16'hC4FB, 32'(ADJ));
		chk(32'(synth_word_o), 32'h0F43, "offset sum 2");
		busy_len(16'hC4F3, 32'h0);
		adj_meas_offset = 5'h0A;
		busy_len(16'hC4FA, 32'h0);
		host.cmd(16'hC4F1);
		tick(3);
		chk({27'h0, adj_offset_o}, 32'h04, "no calc");
		chk(32'(synth_word_o), 32'h0F3F, "apply off");
	endtask : t_adjust

	task automatic t_fifo();
		logic full_seen;
		full_seen = 1'b0;
		tx_data_reg_enable = 1'b1;
		tx_enable = 1'b1;
		host.open_frame();
		host.send_byte(8'hB8);
		tick(4);
		chk(32'(spi_sdo), 32'h1, "room flag");
		for (int i = 0; i < 14; i++) begin
			host.send_byte(8'(i) ^ 8'h5A);
			if (spi_sdo === 1'b0) full_seen = 1'b1;
		end
		for (int t = 0; t < 4000 && spi_sdo !== 1'b1; t++) tick(1);
		chk(32'(spi_sdo), 32'h1, "drained");
		if (spi_sdo !== 1'b1) end_sim();
		host.close_frame();
		chk(32'(full_seen), 32'h1, "full flag");
		tx_enable = 1'b0;
	endtask : t_fifo

	// ===
	// main sequence
	initial begin
		{rstn, tx_data_pin, tx_data_reg_enable, tx_enable, adj_meas_offset} = '0;
		band_code = 2'h1;
		tick(12);
		rstn = 1'b1;
		tick(4);
		t_reset_tx();
		t_decode();
		t_txcfg();
		t_manual();
		t_freq();
		t_adjust();
		t_fifo();
		end_sim();
	end

endmodule : rtfc_regs_tb_top

bind rtfc_regs rtfc_regs_props #(.ADJ_CYC(ADJ_CYC)) u_props (
	.clk(clk), .rstn(rstn), .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo), .tx_data_pin(tx_data_pin),
	.tx_data_reg_enable(tx_data_reg_enable), .band_code(band_code), .afa_o(afa_o),
	.txcfg_o(txcfg_o), .freq_o(freq_o), .rxctl_o(rxctl_o), .adj_busy_o(adj_busy_o),
	.adj_offset_o(adj_offset_o), .synth_word_o(synth_word_o), .carrier_hz_o(carrier_hz_o),
	.step_hz_o(step_hz_o), .dev_khz_o(dev_khz_o), .atten_db_o(atten_db_o),
	.tx_freq_high_o(tx_freq_high_o));

`default_nettype wire
